//--- hw/etc_defines.vh
`ifndef ETC_DEFINES_VH
`define ETC_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ETC_ADDR_W           8
`define ETC_OFS_CONTROL      8'h15
`define ETC_OFS_COMPARE      8'h19

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ETC_CTL_RUN_BIT      5
`define ETC_CTL_SRC_HI       4
`define ETC_CTL_SRC_LO       2
`define ETC_CTL_MODE_HI      1
`define ETC_CTL_MODE_LO      0
`define ETC_CTL_IMPL_MASK    8'h3f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ETC_RST_CONTROL      8'h00
`define ETC_RST_COMPARE      8'hff

// ----------------------------------------------------------------
// Operating mode codes
// ----------------------------------------------------------------
`define ETC_MODE_TIMER       2'h0
`define ETC_MODE_RSVD        2'h1
`define ETC_MODE_DIVIDER     2'h2
`define ETC_MODE_PWM         2'h3

// ----------------------------------------------------------------
// Source clock codes and prescaler exponents
// ----------------------------------------------------------------
`define ETC_SRC_SLOWEST      3'h0
`define ETC_SRC_EXTERNAL     3'h7
`define ETC_EXP_SRC0         4'hb
`define ETC_EXP_SRC1         4'h7
`define ETC_EXP_SRC2         4'h5
`define ETC_EXP_SRC3         4'h3
`define ETC_EXP_SRC4         4'h2
`define ETC_EXP_SRC5         4'h1
`define ETC_EXP_SRC6         4'h0
`define ETC_PRE_TAPS         13
`define ETC_LF_DIV_LOG2      3

`endif

//--- hw/etc_prescaler.v
`timescale 1ns/1ns
`include "etc_defines.vh"

// ----------------------------------------------------------------
// Free-running divider chain
// ----------------------------------------------------------------
// Tap e pulses for one cycle every 2^e cycles of clk; the low
// frequency input is counted on its rising edges and divided by 8.
module etc_prescaler
#(
  parameter TAPS    = `ETC_PRE_TAPS,
  parameter LF_LOG2 = `ETC_LF_DIV_LOG2
)
(
  input  wire            clk,
  input  wire            rst_n,
  input  wire            low_freq_clock,
  output reg  [TAPS-1:0] tap_r,
  output reg             lf_tick_r
);

  reg  [TAPS-2:0]    div_cnt_r;
  reg  [LF_LOG2-1:0] lf_cnt_r;
  reg                lf_prev_r;
  wire [TAPS-1:0]    tap_nxt;
  wire               lf_rise;

  assign tap_nxt[0] = 1'b1;
  assign lf_rise    = low_freq_clock & ~lf_prev_r;

  genvar e;
  generate
    for (e = 1; e < TAPS; e = e + 1)
    begin : g_tap
      assign tap_nxt[e] = &div_cnt_r[e-1:0];
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt_r <= {(TAPS-1){1'b0}};
      tap_r     <= {TAPS{1'b0}};
      lf_cnt_r  <= {LF_LOG2{1'b0}};
      lf_prev_r <= 1'b0;
      lf_tick_r <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 1'b1;
      tap_r     <= tap_nxt;
      lf_prev_r <= low_freq_clock;
      lf_tick_r <= 1'b0;
      if (lf_rise)
      begin
        lf_cnt_r <= lf_cnt_r + 1'b1;
        if (&lf_cnt_r)
          lf_tick_r <= 1'b1;
      end
    end
  end

endmodule

//--- hw/etc_timer.v
// Notes on behaviour
// R1 - Run bit 0 stops and clears the counter; run bit 1 starts counting.
// R2 - Software keeps mode and source fields fixed around start, stop and running.
// R3 - Source codes 000..110 pick fc/2^11,7,5,3,2,1,0; halving doubles each divisor.
// R4 - Prescaler source 1 or slow/sleep: code 000 is low clock /8, others dead in slow.
// R5 - Timer mode counts internal ticks; match raises request, clears, resumes.
// R6 - Event mode, code 111, counts rising edges of the external count input.
// R7 - Event mode matches on the first falling edge after reaching the compare value.
// R8 - External count levels each last over two machine cycles, eight fc periods.
// R9 - Software writes compare values 1 through 255 only, never zero.
// R10 - Entering stop power mode clears the run bit and halts counting.
// R11 - Control bits 7 and 6 are unimplemented and read undefined.
// R12 - Compare is not rewritten while running in timer, event and divider modes.
// R13 - Code 110 is not used when the high-frequency clock exceeds 10 MHz.
// R14 - Event and pulse-width modes only in normal or idle power modes.
// R15 - No low-frequency source while that oscillator is stopped.
// R16 - Source codes must suit the selected mode.
// R17 - Four behaviours from the 2-bit mode field; timer and event share a code.
// R18 - Reset: compare reads all ones, implemented control bits read zero.
// R19 - Divider mode: match toggles divider output, raises request, clears counter.
// R20 - Pulse-width mode: match drives output low; overflow drives high and requests.
// R21 - Pulse-width compare writes take effect at period end, first at start.
// R22 - While stopped both output pins are driven high.
// R23 - Mode 00 timer/event, 01 reserved and idle, 10 divider, 11 pulse-width.
// R24 - The match request is a single-cycle pulse on clk.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "etc_defines.vh"

module etc_timer
#(
  parameter DATA_W = 8,
  parameter ADDR_W = `ETC_ADDR_W
)
(
  input  wire              clk,
  input  wire              rst_n,
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [DATA_W-1:0] reg_wr_data,
  input  wire              reg_wr_en,
  input  wire              reg_rd_en,
  output reg  [DATA_W-1:0] reg_rd_data_r,
  input  wire              prescaler_source_select,
  input  wire              prescaler_halving_select,
  input  wire              slow_power_mode,
  input  wire              stop_mode_enter,
  input  wire              low_freq_clock,
  input  wire              external_count_input,
  output reg               match_interrupt_request_r,
  output reg               divider_output_pin_r,
  output reg               pulse_width_output_pin_r
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg  [DATA_W-1:0] timer_control_r;
  reg  [DATA_W-1:0] timer_compare_value_r;
  reg  [DATA_W-1:0] active_compare_r;
  reg  [DATA_W-1:0] count_r;
  reg  [DATA_W-1:0] count_nxt;
  reg               ext_prev_r;
  reg               irq_nxt;
  reg               pdo_nxt;
  reg               pwm_nxt;
  reg               load_nxt;
  reg  [3:0]        tap_exp;
  reg               int_tick;

  wire [`ETC_PRE_TAPS-1:0] tap;
  wire                     lf_tick;
  wire                     run;
  wire [2:0]               src;
  wire [1:0]               mode;
  wire                     ext_sel;
  wire                     ext_rise;
  wire                     ext_fall;
  wire                     wr_ctl;
  wire                     wr_cmp;
  wire                     run_start;
  wire [DATA_W-1:0]        count_inc;
  wire [DATA_W-1:0]        match_val;

  assign run       = timer_control_r[`ETC_CTL_RUN_BIT];
  assign src       = timer_control_r[`ETC_CTL_SRC_HI:`ETC_CTL_SRC_LO];
  assign mode      = timer_control_r[`ETC_CTL_MODE_HI:`ETC_CTL_MODE_LO];
  assign ext_sel   = (src == `ETC_SRC_EXTERNAL);
  assign ext_rise  = external_count_input & ~ext_prev_r;
  assign ext_fall  = ~external_count_input & ext_prev_r;
  assign wr_ctl    = reg_wr_en && (reg_addr == `ETC_OFS_CONTROL);
  assign wr_cmp    = reg_wr_en && (reg_addr == `ETC_OFS_COMPARE);
  assign run_start = wr_ctl && reg_wr_data[`ETC_CTL_RUN_BIT] && !run && !stop_mode_enter;
  assign count_inc = count_r + 1'b1;

  // Only the pulse-width mode compares against the buffered copy; the
  // other modes forbid rewrites while running, so they use the register.
  assign match_val = (mode == `ETC_MODE_PWM) ? active_compare_r : timer_compare_value_r; // R21

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  etc_prescaler
  #(
    .TAPS    (`ETC_PRE_TAPS),
    .LF_LOG2 (`ETC_LF_DIV_LOG2)
  )
  u_prescaler
  (
    .clk            (clk),
    .rst_n          (rst_n),
    .low_freq_clock (low_freq_clock),
    .tap_r          (tap),
    .lf_tick_r      (lf_tick)
  );

  // ----------------------------------------------------------------
  // Internal count clock selection
  // ----------------------------------------------------------------
  always @*
  begin
    tap_exp  = `ETC_EXP_SRC0;
    int_tick = 1'b0;
    case (src)
      3'h0: tap_exp = `ETC_EXP_SRC0; // R3
      3'h1: tap_exp = `ETC_EXP_SRC1;
      3'h2: tap_exp = `ETC_EXP_SRC2;
      3'h3: tap_exp = `ETC_EXP_SRC3;
      3'h4: tap_exp = `ETC_EXP_SRC4;
      3'h5: tap_exp = `ETC_EXP_SRC5;
      3'h6: tap_exp = `ETC_EXP_SRC6;
      default: tap_exp = `ETC_EXP_SRC0;
    endcase
    tap_exp = tap_exp + {3'h0, prescaler_halving_select}; // R3
    if (src == `ETC_SRC_SLOWEST && (prescaler_source_select || slow_power_mode))
    begin
      int_tick = lf_tick; // R4
    end
    else if (slow_power_mode || ext_sel)
    begin
      int_tick = 1'b0; // R4
    end
    else
    begin
      int_tick = tap[tap_exp];
    end
  end

  // ----------------------------------------------------------------
  // Counter behaviour per mode
  // ----------------------------------------------------------------
  always @*
  begin
    count_nxt = count_r;
    irq_nxt   = 1'b0;
    pdo_nxt   = divider_output_pin_r;
    pwm_nxt   = pulse_width_output_pin_r;
    load_nxt  = 1'b0;
    if (!run)
    begin
      count_nxt = {DATA_W{1'b0}}; // R1
      pdo_nxt   = 1'b1; // R22
      pwm_nxt   = 1'b1; // R22
    end
    else
    begin
      case (mode) // R17
        `ETC_MODE_TIMER:
        begin
          if (ext_sel)
          begin
            if (ext_fall && count_r == match_val)
            begin
              count_nxt = {DATA_W{1'b0}}; // R7
              irq_nxt   = 1'b1; // R7
            end
            else if (ext_rise)
            begin
              count_nxt = count_inc; // R6
            end
          end
          else if (int_tick)
          begin
            if (count_inc == match_val)
            begin
              count_nxt = {DATA_W{1'b0}}; // R5
              irq_nxt   = 1'b1; // R5
            end
            else
            begin
              count_nxt = count_inc; // R5
            end
          end
        end
        `ETC_MODE_DIVIDER:
        begin
          if (int_tick)
          begin
            if (count_inc == match_val)
            begin
              count_nxt = {DATA_W{1'b0}}; // R19
              irq_nxt   = 1'b1; // R19
              pdo_nxt   = ~divider_output_pin_r; // R19
            end
            else
            begin
              count_nxt = count_inc;
            end
          end
        end
        `ETC_MODE_PWM:
        begin
          if (int_tick)
          begin
            count_nxt = count_inc; // R20
            if (&count_r)
            begin
              pwm_nxt  = 1'b1; // R20
              irq_nxt  = 1'b1; // R20
              load_nxt = 1'b1; // R21
            end
            else if (count_inc == match_val)
            begin
              pwm_nxt = 1'b0; // R20
            end
          end
        end
        default:
        begin
          count_nxt = {DATA_W{1'b0}}; // R23
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file and counter state
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      timer_control_r           <= `ETC_RST_CONTROL; // R18
      timer_compare_value_r     <= `ETC_RST_COMPARE; // R18
      active_compare_r          <= `ETC_RST_COMPARE;
      count_r                   <= {DATA_W{1'b0}};
      ext_prev_r                <= 1'b0;
      match_interrupt_request_r <= 1'b0;
      divider_output_pin_r      <= 1'b1;
      pulse_width_output_pin_r  <= 1'b1;
    end
    else
    begin
      ext_prev_r                <= external_count_input;
      count_r                   <= count_nxt;
      match_interrupt_request_r <= irq_nxt; // R24
      divider_output_pin_r      <= pdo_nxt;
      pulse_width_output_pin_r  <= pwm_nxt;
      // Stop entry outranks a simultaneous software write, so the
      // counter can never be left running into the stopped clock.
      if (stop_mode_enter)
      begin
        timer_control_r[`ETC_CTL_RUN_BIT] <= 1'b0; // R10
      end
      else if (wr_ctl)
      begin
        timer_control_r <= reg_wr_data & `ETC_CTL_IMPL_MASK; // R1
      end
      if (wr_cmp)
      begin
        timer_compare_value_r <= reg_wr_data;
      end
      // A write landing in the same cycle as a period end is taken
      // straight into the active copy rather than producing garbage.
      if (run_start || load_nxt)
      begin
        active_compare_r <= wr_cmp ? reg_wr_data : timer_compare_value_r; // R21
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rd_data_r <= {DATA_W{1'b0}};
    end
    else if (reg_rd_en)
    begin
      if (reg_addr == `ETC_OFS_CONTROL)
      begin
        reg_rd_data_r <= timer_control_r & `ETC_CTL_IMPL_MASK; // R11
      end
      else if (reg_addr == `ETC_OFS_COMPARE)
      begin
        reg_rd_data_r <= timer_compare_value_r;
      end
      else
      begin
        reg_rd_data_r <= {DATA_W{1'b0}};
      end
    end
    else
    begin
      reg_rd_data_r <= {DATA_W{1'b0}};
    end
  end

endmodule

//--- dv/etc_pulse_src.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// External count source
// ----------------------------------------------------------------
// Widths below the legal minimum are stretched, so no scenario can
// break the level-width limit by accident.
module etc_pulse_src
(
  input  wire       clk,
  input  wire       go,
  input  wire [7:0] n_pulses,
  input  wire [4:0] width,
  output logic      pin,
  output logic      busy
);
  int w;

  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        busy <= 1'b1;
        w = (width < 8) ? 8 : width;
        repeat (n_pulses)
        begin
          pin <= 1'b1;
          repeat (w + 1) @(posedge clk);
          pin <= 1'b0;
          repeat (w + 1) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

//--- dv/etc_timer_chk.sv
`timescale 1ns/1ns
module etc_timer_chk
(
  input wire       clk,
  input wire       rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire       reg_wr_en,
  input wire       reg_rd_en,
  input wire [7:0] reg_rd_data_r,
  input wire       stop_mode_enter,
  input wire       external_count_input,
  input wire       match_interrupt_request_r,
  input wire       divider_output_pin_r,
  input wire       pulse_width_output_pin_r
);
  // ----------------------------------------------------------------
  // Shadow of the control register
  // ----------------------------------------------------------------
  reg [7:0] ctl_r;

  always @(posedge clk)
    if (!rst_n)
      ctl_r <= 8'h00;
    else if (stop_mode_enter)
      ctl_r <= ctl_r & 8'hdf;
    else if (reg_wr_en && reg_addr == 8'h15)
      ctl_r <= reg_wr_data;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_rd_idle_zero: assert property (!reg_rd_en |=> reg_rd_data_r == 8'h00)
    else $error("read data not zero outside a read");
  chk_rd_unmapped: assert property (reg_rd_en && reg_addr != 8'h15 && reg_addr != 8'h19 |=> reg_rd_data_r == 8'h00)
    else $error("unmapped read not zero");
  chk_ctl_top_bits: assert property (reg_rd_en && reg_addr == 8'h15 |=> reg_rd_data_r[7:6] == 2'h0)
    else $error("control top bits not zero");
  chk_reset_pins: assert property ($rose(rst_n) |-> divider_output_pin_r && pulse_width_output_pin_r)
    else $error("pins not high after reset");
  chk_stop_pins: assert property (stop_mode_enter |-> ##[2:3] (divider_output_pin_r && pulse_width_output_pin_r))
    else $error("pins not high after stop entry");
  chk_stop_quiet: assert property (stop_mode_enter |-> ##3 !match_interrupt_request_r [*8])
    else $error("request after stop entry");
  chk_run_off_pins: assert property (reg_wr_en && reg_addr == 8'h15 && !reg_wr_data[5]
    |-> ##[1:3] (divider_output_pin_r && pulse_width_output_pin_r))
    else $error("pins not high after run cleared");
  chk_pwm_overflow: assert property (ctl_r[1:0] == 2'h3 && match_interrupt_request_r
    |-> pulse_width_output_pin_r && !$past(pulse_width_output_pin_r))
    else $error("pulse-width pin did not rise with request");
  chk_div_toggle: assert property (ctl_r[1:0] == 2'h2 && match_interrupt_request_r
    |-> divider_output_pin_r != $past(divider_output_pin_r))
    else $error("divider pin did not toggle with request");
  chk_rsvd_idle: assert property (ctl_r[1:0] == 2'h1 && $past(ctl_r[1:0]) == 2'h1 |-> !match_interrupt_request_r)
    else $error("request in reserved mode");
  chk_evt_on_fall: assert property (ctl_r[4:0] == 5'h1c && match_interrupt_request_r |-> !$past(external_count_input))
    else $error("event request not after a falling edge");
endmodule

bind etc_timer etc_timer_chk chk_u (.*);

//--- dv/test_etc_timer.sv
`timescale 1ns/1ns
module test_etc_timer;
  logic       clk, rst_n, we, re, pss, phs, slow, stp, lfc, ev_go;
  logic [7:0] addr, wd, rdat, ev_n, v, cmp;
  logic [4:0] ev_w;
  wire        irq, dpin, ppin, ext, ev_busy;
  int         error_cnt, check_count, seed, cyc, hi_cnt, irq_cnt, lf_cnt, t0, t1, h0, h1, k, hs;
  int         ex[7] = '{11, 7, 5, 3, 2, 1, 0};

  etc_timer dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_data(wd), .reg_wr_en(we),
    .reg_rd_en(re), .reg_rd_data_r(rdat), .prescaler_source_select(pss), .prescaler_halving_select(phs),
    .slow_power_mode(slow), .stop_mode_enter(stp), .low_freq_clock(lfc), .external_count_input(ext),
    .match_interrupt_request_r(irq), .divider_output_pin_r(dpin), .pulse_width_output_pin_r(ppin));
  etc_pulse_src src_u (.clk(clk), .go(ev_go), .n_pulses(ev_n), .width(ev_w), .pin(ext), .busy(ev_busy));

  // ----------------------------------------------------------------
  // Clock, slow clock and observers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    lf_cnt <= lf_cnt + 1;
    lfc <= lf_cnt[2];
  end

  always @(negedge clk)
  begin
    cyc++;
    if (ppin === 1'b1) hi_cnt++;
    if (irq === 1'b1) irq_cnt++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdat;
  endtask

  // Sampling after the falling edge keeps the counters settled.
  task automatic wirq(input int lim, output int t);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < lim);
    t = (irq === 1'b1) ? cyc : -1;
  endtask

  // Mode and source change only while stopped, so the run bit is cleared first.
  task automatic start(input logic [7:0] ctl, input logic [7:0] c);
    wr(8'h15, 8'h00);
    wr(8'h19, c);
    wr(8'h15, ctl);
  endtask

  task automatic period(output int dt);
    wirq(20000, t0);
    h0 = hi_cnt;
    wirq(20000, t1);
    h1 = hi_cnt;
    dt = (t0 < 0 || t1 < 0) ? -1 : t1 - t0;
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    error_cnt++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, we, re, pss, phs, slow, stp, ev_go} = 8'h00;
    {addr, wd, ev_n} = 24'h0;
    ev_w = 5'h08;
    seed = 46;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h19, v); chk(v, 16'h00ff);
    rd(8'h15, v); chk(v, 16'h0000);
    rd(8'h00, v); chk(v, 16'h0000);
    wr(8'h15, 8'hc0);
    rd(8'h15, v); chk(v, 16'h0000);
    for (int h = 0; h < 2; h++)
      for (int c = 0; c < 6; c++)
      begin
        wr(8'h15, 8'h00);
        phs <= h[0];
        start(8'h20 | 8'(c << 2) | ((c > 3) ? 8'h03 : 8'h00), 8'h02);
        period(k); chk(k, ((c > 3) ? 256 : 2) << (ex[c] + h));
      end
    wr(8'h15, 8'h00);
    phs <= 1'b0;
    pss <= 1'b1;
    start(8'h20, 8'h02);
    period(k); chk(k, 16'd128);
    wr(8'h15, 8'h00);
    slow <= 1'b1;
    start(8'h20, 8'h02);
    period(k); chk(k, 16'd128);
    pss <= 1'b0;
    start(8'h24, 8'h02);
    wirq(600, k); chk(k, 16'hffff);
    wr(8'h15, 8'h00);
    slow <= 1'b0;
    cmp = 8'd2 + 8'({$random(seed)} % 4);
    ev_w = 5'd8 + 5'({$random(seed)} % 8);
    ev_n = cmp << 1;
    start(8'h3c, cmp);
    h0 = irq_cnt;
    @(posedge clk) ev_go <= 1'b1;
    @(posedge clk) ev_go <= 1'b0;
    k = 0;
    do @(negedge clk); while ((ev_busy !== 1'b0 || k++ < 2) && k < 3000);
    repeat (4) @(negedge clk);
    chk(irq_cnt - h0, 16'd2);
    cmp = 8'd2 + 8'({$random(seed)} % 8);
    start(8'h2a, cmp);
    period(k); chk(k, {3'h0, cmp, 5'h00});
    v = {7'h0, dpin};
    wirq(600, k); chk({15'h0, dpin}, {15'h0, ~v[0]});
    wr(8'h15, 8'h00);
    repeat (3) @(negedge clk);
    chk({15'h0, dpin & ppin}, 16'h0001);
    start(8'h37, 8'h40);
    period(k); chk(k, 16'd512);
    chk(h1 - h0, 16'h0080);
    hs = h1;
    wr(8'h19, 8'h80);
    period(k); chk(h0 - hs, 16'h0080);
    chk(h1 - h0, 16'h0100);
    wirq(600, k); chk(hi_cnt - h1, 16'h0100);
    @(posedge clk) stp <= 1'b1;
    @(posedge clk) stp <= 1'b0;
    rd(8'h15, v); chk(v, 16'h0017);
    wirq(600, k); chk(k, 16'hffff);
    start(8'h25, 8'h02);
    wirq(600, k); chk(k, 16'hffff);
    report_and_stop;
  end
endmodule
